// [rtl/gate_guard_regs.vh]
`ifndef GATE_GUARD_REGS_VH
`define GATE_GUARD_REGS_VH

// Clock period of core_clk in picoseconds and in nanoseconds.
`define CLK_PERIOD_PS 20000
`define CLK_PERIOD_NS 20

// Glitch filter: minimum pulse width per pF of filter capacitance, in ps.
`define GLITCH_PS_PER_PF 500

// Anti-overlap stage: forced dead time per pF of non-overlap capacitance, in ps.
`define DEAD_PS_PER_PF 500

// Local mode: generated non-overlap delay per pF of capacitance, in ps.
`define LOCAL_DEAD_PS_PER_PF 5500

// Desaturation blanking: 14 ns times (capacitance in pF plus 7).
`define BLANK_PS_PER_STEP 14000
`define BLANK_CAP_OFFSET_PF 7
`define BLANK_CAP_DEFAULT_PF 8'h44

// Fault latch period in milliseconds and its cycle count at core_clk.
// The count is 14 ms over 20 ns, sized to the latch counter width.
`define FAULT_LATCH_MS 14
`define FAULT_LATCH_CYCLES 20'haae60

// Counter widths.
`define LATCH_CNT_W 20
`define TIME_CNT_W 16
`define TIME_CNT_MAX 16'hffff

`endif

// [rtl/pwm_glitch_filter.v]
module pwm_glitch_filter
(
  // Clock and reset.
  input  wire        core_clk,
  input  wire        arst_n,
  // Filter setting in cycles, at least one.
  input  wire [15:0] min_cycles,
  // Raw and filtered pulse.
  input  wire        pulse_in,
  output wire        pulse_out
);

  reg [15:0] run_q;
  reg        out_q;

  // A new level must hold for min_cycles samples before the output follows.
  // This rejects short pulses of either polarity and delays every edge that
  // passes by the same amount, so duty cycle is preserved.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_q <= 16'h0000;
      out_q <= 1'b0;
    end
    else if (pulse_in != out_q)
    begin
      if (run_q + 16'h0001 >= min_cycles)
      begin
        out_q <= pulse_in;
        run_q <= 16'h0000;
      end
      else
      begin
        run_q <= run_q + 16'h0001;
      end
    end
    else
    begin
      run_q <= 16'h0000;
    end
  end

  assign pulse_out = out_q;

endmodule

// [rtl/fault_latch.v]
module fault_latch
#(
  parameter [19:0] LATCH_CYCLES = 20'haae60
)
(
  // Clock and reset.
  input  wire core_clk,
  input  wire arst_n,
  // Raw fault condition and latched fault state.
  input  wire raw_fault,
  output wire fault_active
);

  reg [19:0] left_q;
  reg        fault_q;

  // The fault is held for LATCH_CYCLES cycles however brief the cause, then
  // stays set for as long as the cause persists. Reset starts in the fault
  // state with the timer expired so that power-up waits only for the cause.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_q <= 1'b1;
      left_q  <= 20'h00000;
    end
    else if (!fault_q)
    begin
      if (raw_fault)
      begin
        fault_q <= 1'b1;
        left_q  <= LATCH_CYCLES - 20'h00001;
      end
    end
    else if (left_q != 20'h00000)
    begin
      left_q <= left_q - 20'h00001;
    end
    else if (!raw_fault)
    begin
      fault_q <= 1'b0;
    end
  end

  assign fault_active = fault_q;

endmodule

// [rtl/gate_driver_fault_pwm_guard.v]
`include "gate_guard_regs.vh"

// What this block does
// - Filter rejects PWM pulses of either polarity shorter than 0.5 ns per pF.
// - Edges passing the filter are delayed by exactly the filter time.
// - Gates never on together; forced dead time of 0.5 ns per pF outside local mode.
// - Inputs already spaced by the dead time pass with no extra delay.
// - Missing secondary supply raises the primary fault.
// - Desat comparator ignored during blanking after gate rise, then raises desat fault.
// - Blanking time is 14 ns times (capacitance pF plus 7), default 68 pF.
// - A desat fault turns the gate off via soft shutdown.
// - Miller clamp enabled whenever the gate is driven off and no soft shutdown is active.
// - Primary fault is input lockout OR primary power-good lost OR a secondary supply missing.
// - Every combined fault raised after reset stays latched for 14 ms at least.
// - Latched primary fault: both fault outputs low, both gates off, converter off.
// - Primary fault still present after latch keeps the fault state.
// - After primary fault clears, converter on; each PWM resumes at its next rise.
// - Side fault output is primary fault OR that side's fault.
// - Side fault is supply lockout OR power-good lost OR desat fault.
// - Latched side fault holds gate off; entering fault uses soft shutdown.
// - Side fault persisting keeps gate off; resume at next PWM rise.
// - Supply lockout decisions use hysteresis between two thresholds.
// - Local mode derives both drives from high input with own non-overlap.
module gate_driver_fault_pwm_guard
#(
  parameter [19:0] LATCH_CYCLES = `FAULT_LATCH_CYCLES
)
(
  // Clock and reset.
  input  wire       core_clk,
  input  wire       arst_n,
  // PWM inputs from the controller, after the differential receivers.
  input  wire       low_side_pwm_in,
  input  wire       high_side_pwm_in,
  // Board settings: mode strap and capacitances in pF.
  input  wire       local_mode,
  input  wire [7:0] glitch_cap_pf,
  input  wire [7:0] dead_cap_pf,
  input  wire [7:0] local_dead_cap_pf,
  input  wire [7:0] blank_cap_pf,
  // Primary supervision: input supply comparators and regulator power-good.
  input  wire       vin_above_high_thr,
  input  wire       vin_above_low_thr,
  input  wire       prim_power_good,
  // Secondary supervision, index 0 low side, index 1 high side.
  input  wire [1:0] sec_present,
  input  wire [1:0] sec_above_high_thr,
  input  wire [1:0] sec_above_low_thr,
  input  wire [1:0] sec_power_good,
  // Desaturation comparators, high when drain sense is above threshold.
  input  wire       low_drain_sense,
  input  wire       high_drain_sense,
  // Gate drive, soft shutdown and Miller clamp controls.
  output wire       low_gate_drive,
  output wire       high_gate_drive,
  output wire       low_soft_shutdown,
  output wire       high_soft_shutdown,
  output wire       low_miller_clamp,
  output wire       high_miller_clamp,
  // Isolated converter enable.
  output wire       converter_enable,
  // Open-drain fault outputs, pulled low while the enable is high.
  output wire       low_side_fault_out,
  output wire       low_side_fault_out_oe,
  output wire       high_side_fault_out,
  output wire       high_side_fault_out_oe
);

  // Rounds a time in ps up to whole cycles, never below one cycle.
  function [15:0] ps_to_cycles;
    input [31:0] ps;
    reg   [31:0] c;
    begin
      c = (ps + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
      if (c == 32'h00000000)
      begin
        c = 32'h00000001;
      end
      ps_to_cycles = c[15:0];
    end
  endfunction

  wire [15:0] glitch_cyc;
  wire [15:0] dead_cyc;
  wire [15:0] local_dead_cyc;
  wire [15:0] blank_cyc;
  wire [15:0] active_dead_cyc;
  wire        filt_low;
  wire        filt_high;
  wire [1:0]  req;
  wire [1:0]  req_rise;
  wire [1:0]  drain_hi;
  wire        prim_raw;
  wire [1:0]  side_raw;
  wire        prim_flt;
  wire [1:0]  side_flt;
  reg  [1:0]  eff;
  reg  [1:0]  start;
  reg  [1:0]  gate_d;
  reg  [1:0]  soft_d;

  reg  [1:0]  req_q;
  reg         prim_lock_q;
  reg  [1:0]  sec_lock_q;
  reg  [1:0]  desat_q;
  reg  [1:0]  allow_q;
  reg  [1:0]  gate_q;
  reg  [1:0]  soft_q;
  reg  [1:0]  clamp_q;
  reg  [1:0]  side_flt_prev_q;
  reg  [15:0] off_cnt_q [0:1];
  reg  [15:0] blank_cnt_q [0:1];
  reg         conv_en_q;
  reg  [1:0]  fault_oe_q;
  integer     s, k, m, n;

  // Settings turn into cycle counts; they are straps, so they may change
  // only while the gates are held off.
  assign glitch_cyc     = ps_to_cycles({24'h000000, glitch_cap_pf} * `GLITCH_PS_PER_PF);
  assign dead_cyc       = ps_to_cycles({24'h000000, dead_cap_pf} * `DEAD_PS_PER_PF);
  assign local_dead_cyc = ps_to_cycles({24'h000000, local_dead_cap_pf}
                                       * `LOCAL_DEAD_PS_PER_PF);
  assign blank_cyc      = ps_to_cycles(({24'h000000, blank_cap_pf} + `BLANK_CAP_OFFSET_PF)
                                       * `BLANK_PS_PER_STEP);
  assign active_dead_cyc = local_mode ? local_dead_cyc : dead_cyc;

  // One glitch filter per PWM input.
  pwm_glitch_filter u_filt_low
  (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .min_cycles (glitch_cyc),
    .pulse_in   (low_side_pwm_in),
    .pulse_out  (filt_low)
  );

  pwm_glitch_filter u_filt_high
  (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .min_cycles (glitch_cyc),
    .pulse_in   (high_side_pwm_in),
    .pulse_out  (filt_high)
  );

  // In local mode the low side is the complement of the high input; the
  // anti-overlap stage then provides the spacing that the controller omits.
  assign req[0]   = local_mode ? ~filt_high : filt_low;
  assign req[1]   = filt_high;
  assign req_rise = req & ~req_q;
  assign drain_hi = {high_drain_sense, low_drain_sense};

  // Supply lockout with hysteresis: set below the low threshold, cleared
  // only above the high one, so a supply hovering in between stays put.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prim_lock_q <= 1'b1;
      sec_lock_q  <= 2'b11;
    end
    else
    begin
      if (!vin_above_low_thr)
      begin
        prim_lock_q <= 1'b1;
      end
      else if (vin_above_high_thr)
      begin
        prim_lock_q <= 1'b0;
      end
      for (k = 0; k < 2; k = k + 1)
      begin
        if (!sec_above_low_thr[k])
        begin
          sec_lock_q[k] <= 1'b1;
        end
        else if (sec_above_high_thr[k])
        begin
          sec_lock_q[k] <= 1'b0;
        end
      end
    end
  end

  // Raw fault causes, combined before latching.
  assign prim_raw = prim_lock_q | ~prim_power_good
                  | ~sec_present[0] | ~sec_present[1];
  assign side_raw = sec_lock_q | ~sec_power_good | desat_q;

  // Latches for the primary fault and each side fault.
  fault_latch #(.LATCH_CYCLES (LATCH_CYCLES)) u_latch_prim
  (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .raw_fault    (prim_raw),
    .fault_active (prim_flt)
  );

  fault_latch #(.LATCH_CYCLES (LATCH_CYCLES)) u_latch_low
  (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .raw_fault    (side_raw[0]),
    .fault_active (side_flt[0])
  );

  fault_latch #(.LATCH_CYCLES (LATCH_CYCLES)) u_latch_high
  (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .raw_fault    (side_raw[1]),
    .fault_active (side_flt[1])
  );

  // Next gate state. A side may switch on only when the other gate has been
  // off for the dead time; if both try to start in the same cycle neither
  // does, which is safer than picking a winner on an overlapping input.
  always @*
  begin
    eff    = 2'b00;
    start  = 2'b00;
    gate_d = 2'b00;
    soft_d = 2'b00;
    for (s = 0; s < 2; s = s + 1)
    begin
      eff[s]   = req[s] & allow_q[s] & ~prim_flt & ~side_flt[s];
      start[s] = eff[s] & ~gate_q[s] & ~gate_q[1-s]
               & (off_cnt_q[1-s] >= active_dead_cyc);
      soft_d[s] = side_flt[s] & (soft_q[s] | ~side_flt_prev_q[s]);
    end
    for (s = 0; s < 2; s = s + 1)
    begin
      gate_d[s] = eff[s] & (gate_q[s] | (start[s] & ~start[1-s]));
    end
  end

  // Drive permission per side. It drops on the primary fault or that side's own fault and comes back only on
  // a rising request edge once both of those are clear, so a gate never resumes
  // in the middle of a PWM high phase that began during a fault.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      allow_q <= 2'b00;
      req_q   <= 2'b11;
    end
    else
    begin
      req_q <= req;
      for (m = 0; m < 2; m = m + 1)
      begin
        if (prim_flt || side_flt[m])
        begin
          allow_q[m] <= 1'b0;
        end
        else if (req_rise[m])
        begin
          allow_q[m] <= 1'b1;
        end
      end
    end
  end

  // Gate, off-time and blanking counters per side. The off counter saturates
  // so inputs that were apart long enough pass straight through.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gate_q         <= 2'b00;
      soft_q         <= 2'b00;
      clamp_q        <= 2'b11;
      desat_q        <= 2'b00;
      side_flt_prev_q <= 2'b11;
      off_cnt_q[0]   <= `TIME_CNT_MAX;
      off_cnt_q[1]   <= `TIME_CNT_MAX;
      blank_cnt_q[0] <= 16'h0000;
      blank_cnt_q[1] <= 16'h0000;
    end
    else
    begin
      gate_q          <= gate_d;
      soft_q          <= soft_d;
      side_flt_prev_q <= side_flt;
      for (n = 0; n < 2; n = n + 1)
      begin
        // The clamp must not fight a soft shutdown in progress.
        clamp_q[n] <= ~gate_d[n] & ~soft_d[n];
        if (gate_q[n])
        begin
          off_cnt_q[n] <= 16'h0000;
        end
        else if (off_cnt_q[n] != `TIME_CNT_MAX)
        begin
          off_cnt_q[n] <= off_cnt_q[n] + 16'h0001;
        end
        if (!gate_q[n])
        begin
          blank_cnt_q[n] <= 16'h0000;
        end
        else if (blank_cnt_q[n] != blank_cyc)
        begin
          blank_cnt_q[n] <= blank_cnt_q[n] + 16'h0001;
        end
        // The comparator counts only once blanking has run out.
        desat_q[n] <= gate_q[n] & (blank_cnt_q[n] == blank_cyc) & drain_hi[n];
      end
    end
  end

  // Converter and fault pins. Fault pins are asserted out of reset and
  // follow the aggregation of primary and side faults.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      conv_en_q  <= 1'b0;
      fault_oe_q <= 2'b11;
    end
    else
    begin
      conv_en_q     <= ~prim_flt;
      fault_oe_q[0] <= prim_flt | side_flt[0];
      fault_oe_q[1] <= prim_flt | side_flt[1];
    end
  end

  // Output mapping.
  assign low_gate_drive         = gate_q[0];
  assign high_gate_drive        = gate_q[1];
  assign low_soft_shutdown      = soft_q[0];
  assign high_soft_shutdown     = soft_q[1];
  assign low_miller_clamp       = clamp_q[0];
  assign high_miller_clamp      = clamp_q[1];
  assign converter_enable       = conv_en_q;
  assign low_side_fault_out     = 1'b0;
  assign low_side_fault_out_oe  = fault_oe_q[0];
  assign high_side_fault_out    = 1'b0;
  assign high_side_fault_out_oe = fault_oe_q[1];

endmodule

// [tb/gate_guard_properties.sv]
module gate_guard_properties
#(
  parameter [19:0] LATCH_CYCLES = 20'haae60
)
(
  // Clock and reset.
  input logic       core_clk,
  input logic       arst_n,
  // Supervision inputs.
  input logic       vin_above_low_thr,
  input logic       prim_power_good,
  input logic [1:0] sec_power_good,
  // Gate side and fault outputs.
  input logic       low_gate_drive,
  input logic       high_gate_drive,
  input logic       low_soft_shutdown,
  input logic       low_miller_clamp,
  input logic       high_miller_clamp,
  input logic       converter_enable,
  input logic       low_side_fault_out_oe,
  input logic       high_side_fault_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [19:0] held_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Counts pulled cycles of the low fault pin; reset starts saturated so power-up is exempt.
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      held_q <= LATCH_CYCLES;
    else if (!low_side_fault_out_oe)
      held_q <= 20'h0;
    else if (held_q < LATCH_CYCLES)
      held_q <= held_q + 20'h1;

  no_overlap_a: assert property (!(low_gate_drive && high_gate_drive))
    else $error("both gates on together");
  low_clamp_a: assert property (low_miller_clamp == (!low_gate_drive && !low_soft_shutdown))
    else $error("low clamp does not follow gate");
  high_clamp_a: assert property (high_gate_drive |-> !high_miller_clamp)
    else $error("high clamp on with gate on");
  prim_lockout_a: assert property (!vin_above_low_thr |-> ##[1:4] !converter_enable)
    else $error("converter stays on under lockout");
  prim_pg_a: assert property (!prim_power_good |->
    ##[1:4] (low_side_fault_out_oe && high_side_fault_out_oe))
    else $error("fault pins not pulled on power-good loss");
  prim_gates_a: assert property (!converter_enable && !$past(converter_enable) |->
    !low_gate_drive && !high_gate_drive)
    else $error("gate on during primary fault");
  latch_hold_a: assert property (low_side_fault_out_oe && held_q < LATCH_CYCLES - 20'h1 |=>
    low_side_fault_out_oe)
    else $error("low fault released too early");
  soft_off_a: assert property ($rose(low_soft_shutdown) |-> !low_gate_drive)
    else $error("gate still on at soft shutdown");
  sec_pg_a: assert property (!sec_power_good[0] |-> ##[1:4] low_side_fault_out_oe)
    else $error("low fault pin not pulled");
endmodule

// [tb/pwm_controller_model.sv]
module pwm_controller_model
(
  // Requests from the bench.
  input  logic low_req,
  input  logic high_req,
  // Open-drain drivers of the block.
  input  logic low_od,
  input  logic low_oe,
  input  logic high_od,
  input  logic high_oe,
  // PWM lines and resolved fault lines.
  output logic low_pwm,
  output logic high_pwm,
  output logic low_line,
  output logic high_line
);
  timeunit 1ns;
  timeprecision 100ps;

  // The controller drives its receivers straight from its own requests.
  assign low_pwm  = low_req;
  assign high_pwm = high_req;
  // Pull-ups hold the lines high whenever the block releases them.
  assign low_line  = low_oe ? low_od : 1'b1;
  assign high_line = high_oe ? high_od : 1'b1;
endmodule

// [tb/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk, arst_n, lreq, hreq, lpwm, hpwm, local_mode, vin_hi, vin_lo, ppg;
  logic [1:0] sec_pres, sec_hi, sec_lo, sec_pg;
  logic lsense, hsense, lg, hg, lssd, hssd, lcl, hcl, conv;
  logic lfo, lfoe, hfo, hfoe, lline, hline;
  int err_total, compares;

`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end

  // Clock of 20 ns.
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  pwm_controller_model pwm_controller_model_inst (.low_req(lreq), .high_req(hreq),
    .low_od(lfo), .low_oe(lfoe), .high_od(hfo), .high_oe(hfoe), .low_pwm(lpwm),
    .high_pwm(hpwm), .low_line(lline), .high_line(hline));

  // Straps: filter and dead time 2 cycles, local dead 3, blanking 7.
  gate_driver_fault_pwm_guard #(.LATCH_CYCLES(20'd20)) gate_driver_fault_pwm_guard_inst (
    .core_clk(core_clk), .arst_n(arst_n), .low_side_pwm_in(lpwm), .high_side_pwm_in(hpwm),
    .local_mode(local_mode), .glitch_cap_pf(8'h50), .dead_cap_pf(8'h50),
    .local_dead_cap_pf(8'h08), .blank_cap_pf(8'h03), .vin_above_high_thr(vin_hi),
    .vin_above_low_thr(vin_lo), .prim_power_good(ppg), .sec_present(sec_pres),
    .sec_above_high_thr(sec_hi), .sec_above_low_thr(sec_lo), .sec_power_good(sec_pg),
    .low_drain_sense(lsense), .high_drain_sense(hsense), .low_gate_drive(lg),
    .high_gate_drive(hg), .low_soft_shutdown(lssd), .high_soft_shutdown(hssd),
    .low_miller_clamp(lcl), .high_miller_clamp(hcl), .converter_enable(conv),
    .low_side_fault_out(lfo), .low_side_fault_out_oe(lfoe), .high_side_fault_out(hfo),
    .high_side_fault_out_oe(hfoe));

  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Inputs move 2 ns after the edge, away from sampling.
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  // Waits a bounded number of cycles for one observed signal to take a value.
  task automatic poll(input string n, input int sel, input logic v, input int lim);
    logic s;
    for (int i = 0; i <= lim; i++)
    begin
      s = (sel == 0) ? lg : (sel == 1) ? hg : (sel == 2) ? lline : hline;
      if (s === v)
        break;
      tk(1);
    end
    `CHK(n, v, s)
  endtask

  task automatic t_path();
    hreq = 1'b1;
    tk(1);
    hreq = 1'b0;
    tk(6);
    `CHK("short high pulse", 1'b0, hg)
    lreq = 1'b1;
    tk(1);
    `CHK("low gate early", 1'b0, lg)
    poll("low gate on", 0, 1'b1, 3);
    lreq = 1'b0;
    tk(1);
    lreq = 1'b1;
    tk(5);
    `CHK("negative glitch", 1'b1, lg)
    hreq = 1'b1;
    tk(6);
    `CHK("high refused", 1'b0, hg)
    hreq = 1'b0;
    lreq = 1'b0;
    poll("low gate off", 0, 1'b0, 4);
    tk(10);
    hreq = 1'b1;
    poll("high spaced on", 1, 1'b1, 4);
    hreq = 1'b0;
    tk(6);
    // The high side is armed now, so a passed glitch would show on the gate.
    hreq = 1'b1;
    tk(1);
    hreq = 1'b0;
    repeat (6)
    begin
      tk(1);
      `CHK("armed short pulse", 1'b0, hg)
    end
  endtask

  task automatic t_desat();
    lreq = 1'b1;
    poll("desat gate on", 0, 1'b1, 4);
    lsense = 1'b1;
    tk(5);
    `CHK("blanking", 1'b1, lline)
    poll("desat fault", 2, 1'b0, 8);
    `CHK("soft shutdown", 1'b1, lssd)
    `CHK("desat gate off", 1'b0, lg)
    `CHK("other side clean", 1'b1, hline)
    lsense = 1'b0;
    tk(14);
    `CHK("desat latched", 1'b0, lline)
    poll("desat clear", 2, 1'b1, 12);
    tk(4);
    `CHK("wait for rise", 1'b0, lg)
    lreq = 1'b0;
    tk(4);
    lreq = 1'b1;
    poll("resume", 0, 1'b1, 4);
    lreq = 1'b0;
    tk(6);
  endtask

  task automatic t_latch();
    sec_pg[0] = 1'b0;
    tk(1);
    sec_pg[0] = 1'b1;
    poll("side fault", 2, 1'b0, 4);
    `CHK("high pin free", 1'b1, hline)
    `CHK("low soft shutdown", 1'b1, lssd)
    `CHK("low clamp off", 1'b0, lcl)
    tk(15);
    `CHK("side latched", 1'b0, lline)
    poll("side clear", 2, 1'b1, 10);
    sec_pg[1] = 1'b0;
    tk(1);
    sec_pg[1] = 1'b1;
    poll("high side fault", 3, 1'b0, 4);
    `CHK("high soft shutdown", 1'b1, hssd)
    `CHK("high clamp off", 1'b0, hcl)
    `CHK("low pin free", 1'b1, lline)
    poll("high side clear", 3, 1'b1, 30);
    sec_pres[1] = 1'b0;
    tk(1);
    sec_pres[1] = 1'b1;
    poll("no supply fault", 2, 1'b0, 4);
    `CHK("no supply high pin", 1'b0, hline)
    poll("no supply clear", 3, 1'b1, 30);
  endtask

  task automatic t_prim();
    lreq = 1'b1;
    poll("prim gate on", 0, 1'b1, 4);
    ppg = 1'b0;
    tk(1);
    ppg = 1'b1;
    poll("prim low pin", 2, 1'b0, 4);
    `CHK("prim high pin", 1'b0, hline)
    tk(1);
    `CHK("converter off", 1'b0, conv)
    `CHK("prim gate off", 1'b0, lg)
    vin_lo = 1'b0;
    vin_hi = 1'b0;
    tk(1);
    vin_lo = 1'b1;
    tk(30);
    `CHK("hysteresis hold", 1'b0, hline)
    vin_hi = 1'b1;
    poll("prim clear", 3, 1'b1, 25);
    tk(2);
    `CHK("converter back", 1'b1, conv)
    `CHK("prim wait rise", 1'b0, lg)
    lreq = 1'b0;
    tk(4);
    lreq = 1'b1;
    poll("prim resume", 0, 1'b1, 4);
    lreq = 1'b0;
    tk(6);
  endtask

  task automatic t_local();
    local_mode = 1'b1;
    tk(6);
    hreq = 1'b1;
    poll("local high on", 1, 1'b1, 8);
    hreq = 1'b0;
    tk(2);
    `CHK("local dead", 1'b0, lg)
    poll("local low on", 0, 1'b1, 10);
    local_mode = 1'b0;
    poll("local low off", 0, 1'b0, 6);
  endtask

  // Main sequence: everything good, reset for five cycles, then the scenarios.
  initial
  begin
    {arst_n, lreq, hreq, local_mode, lsense, hsense} = 6'h00;
    {vin_hi, vin_lo, ppg} = 3'h7;
    {sec_pres, sec_hi, sec_lo, sec_pg} = 8'hff;
    err_total = 0;
    compares = 0;
    tk(5);
    arst_n = 1'b1;
    poll("power-up clear", 2, 1'b1, 10);
    t_path();
    t_desat();
    t_latch();
    t_prim();
    t_local();
    give_verdict();
  end
endmodule

bind gate_driver_fault_pwm_guard gate_guard_properties #(.LATCH_CYCLES(LATCH_CYCLES))
  gate_guard_properties_inst (.core_clk(core_clk), .arst_n(arst_n),
  .vin_above_low_thr(vin_above_low_thr), .prim_power_good(prim_power_good),
  .sec_power_good(sec_power_good), .low_gate_drive(low_gate_drive),
  .high_gate_drive(high_gate_drive), .low_soft_shutdown(low_soft_shutdown),
  .low_miller_clamp(low_miller_clamp), .high_miller_clamp(high_miller_clamp),
  .converter_enable(converter_enable), .low_side_fault_out_oe(low_side_fault_out_oe),
  .high_side_fault_out_oe(high_side_fault_out_oe));
